/* sep_command_port.sv */
`default_nettype none
module sep_command_port
  import sep_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF
)
(
  // core clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // serial link from host
  input wire logic serial_clock_in,
  input wire logic chip_select_in,
  input wire logic serial_data_in,
  // serial data output pin
  output logic serial_data_out,
  output logic serial_data_oe,
  // supply monitor
  input wire logic low_supply_in
);
  localparam int TIMER_W = $clog2(PROG_CYCLES + 1);
  localparam logic [TIMER_W-1:0] PROG_LAST = TIMER_W'(PROG_CYCLES - 1);

  // ----------------------------------------------------------------
  // array
  // ----------------------------------------------------------------
  sep_mem_if #(.AW(ADDR_W), .DW(WORD_W)) mem_bus ();

  sep_mem #(.AW(ADDR_W), .DW(WORD_W)) u_mem (
    .wr_clk(core_clk),
    .rd_clk(serial_clock_in),
    .port(mem_bus.mem)
  );

  // ----------------------------------------------------------------
  // link domain
  // ----------------------------------------------------------------
  logic link_rst_n;
  sep_link_state_t lstate;
  logic [CNT_W-1:0] bit_cnt;
  logic [WBIT_W-1:0] word_bit;
  logic start_seen;
  logic rd_oe;
  logic rd_bit;
  logic [WORD_W-1:0] rd_shift;
  logic [ADDR_W-1:0] rd_addr;
  logic [ADDR_W-1:0] next_rd_addr;
  logic [HDR_BITS-1:0] hdr_sr;
  logic [HDR_BITS-1:0] hdr_full;
  logic [WORD_W-1:0] data_sr;
  logic op_toggle;
  logic busy_l1;
  logic busy_l;
  logic hdr_last;
  logic [1:0] f_op;
  logic [1:0] f_sub;
  logic busy;

  // frame state is cleared whenever the chip is deselected
  assign link_rst_n = rst_n & chip_select_in;
  assign hdr_full = {hdr_sr[HDR_BITS-2:0], serial_data_in};
  assign f_op = hdr_full[HDR_BITS-1 -: OP_W];
  assign f_sub = hdr_full[ADDR_W-1 -: 2];
  assign hdr_last = (lstate == LS_HDR) &&
                    (bit_cnt == CNT_W'(HDR_BITS - 1));

  always_comb
  begin
    next_rd_addr = rd_addr;
    if (hdr_last && f_op == OP_READ)
    begin
      next_rd_addr = hdr_full[ADDR_W-1:0];
    end
    else if (lstate == LS_READ && word_bit == WBIT_LAST)
    begin
      next_rd_addr = rd_addr + 1'b1;
    end
  end

  assign mem_bus.rd_addr = next_rd_addr;

  // frame sequencer
  always_ff @(posedge serial_clock_in or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      lstate <= LS_IDLE;
      bit_cnt <= '0;
      word_bit <= '0;
      start_seen <= 1'b0;
      rd_oe <= 1'b0;
      rd_bit <= 1'b0;
      rd_shift <= '0;
      rd_addr <= '0;
    end
    else
    begin
      rd_addr <= next_rd_addr;
      unique case (lstate)
        LS_IDLE:
        begin
          // low data bits are dummy clocks; busy blocks new frames
          if (serial_data_in && !busy_l)
          begin
            lstate <= LS_HDR;
            start_seen <= 1'b1;
            bit_cnt <= '0;
          end
        end
        LS_HDR:
        begin
          bit_cnt <= bit_cnt + 1'b1;
          if (hdr_last)
          begin
            bit_cnt <= '0;
            if (f_op == OP_READ)
            begin
              lstate <= LS_READ;
              rd_oe <= 1'b1;
              rd_bit <= 1'b0;
              word_bit <= '0;
            end
            else if (sep_needs_data(f_op, f_sub))
            begin
              lstate <= LS_DATA;
            end
            else
            begin
              lstate <= LS_DONE;
            end
          end
        end
        LS_READ:
        begin
          word_bit <= word_bit + 1'b1;
          if (word_bit == '0)
          begin
            rd_bit <= mem_bus.rd_data[WORD_W-1];
            rd_shift <= {mem_bus.rd_data[WORD_W-2:0], 1'b0};
          end
          else
          begin
            rd_bit <= rd_shift[WORD_W-1];
            rd_shift <= {rd_shift[WORD_W-2:0], 1'b0};
          end
        end
        LS_DATA:
        begin
          if (bit_cnt != CNT_W'(WORD_W))
          begin
            bit_cnt <= bit_cnt + 1'b1;
          end
        end
        LS_DONE:
        begin
          lstate <= LS_DONE;
        end
        default:
        begin
          lstate <= LS_IDLE;
        end
      endcase
    end
  end

  // command capture; held stable while deselected for the core
  always_ff @(posedge serial_clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hdr_sr <= '0;
      data_sr <= '0;
      op_toggle <= 1'b0;
    end
    else
    begin
      if (lstate == LS_HDR)
      begin
        hdr_sr <= hdr_full;
      end
      if (lstate == LS_DATA)
      begin
        data_sr <= {data_sr[WORD_W-2:0], serial_data_in};
      end
      if ((hdr_last && f_op != OP_READ && !sep_needs_data(f_op, f_sub)) ||
          (lstate == LS_DATA && bit_cnt == CNT_W'(WORD_W - 1)))
      begin
        op_toggle <= !op_toggle;
      end
    end
  end

  // busy flag into the link domain
  always_ff @(posedge serial_clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_l1 <= 1'b0;
      busy_l <= 1'b0;
    end
    else
    begin
      busy_l1 <= busy;
      busy_l <= busy_l1;
    end
  end

  // ----------------------------------------------------------------
  // core domain
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] sync_m;
  logic [SYNC_W-1:0] sync_s;
  logic cs_s;
  logic low_s;
  logic tog_s;
  logic start_s;
  logic rdoe_s;
  logic rdbit_s;
  logic seen;
  logic act;
  logic prog_en;
  logic status_mode;
  sep_core_state_t cstate;
  logic [TIMER_W-1:0] timer;
  logic c_all;
  logic [ADDR_W-1:0] c_addr;
  logic [WORD_W-1:0] c_data;
  logic [1:0] c_op;
  logic [1:0] c_sub;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_m <= '0;
      sync_s <= '0;
    end
    else
    begin
      sync_m <= {chip_select_in, low_supply_in, op_toggle, start_seen,
                 rd_oe, rd_bit};
      sync_s <= sync_m;
    end
  end

  assign {cs_s, low_s, tog_s, start_s, rdoe_s, rdbit_s} = sync_s;
  assign c_op = hdr_sr[HDR_BITS-1 -: OP_W];
  assign c_sub = hdr_sr[ADDR_W-1 -: 2];
  // a completed command is acted on once the chip is deselected
  assign act = !cs_s && (tog_s != seen);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seen <= 1'b0;
    end
    else if (act)
    begin
      seen <= tog_s;
    end
  end

  // programming mode
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prog_en <= 1'b0;
    end
    else if (low_s)
    begin
      prog_en <= 1'b0;
    end
    else if (act && !busy && c_op == OP_SPECIAL)
    begin
      if (c_sub == SUB_PROG_ON)
      begin
        prog_en <= 1'b1;
      end
      else if (c_sub == SUB_PROG_OFF)
      begin
        prog_en <= 1'b0;
      end
    end
  end

  // programming sequencer
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cstate <= CS_IDLE;
      busy <= 1'b0;
      timer <= '0;
      c_all <= 1'b0;
      c_addr <= '0;
      c_data <= ERASED_WORD;
    end
    else if (low_s)
    begin
      cstate <= CS_IDLE;
      busy <= 1'b0;
      timer <= '0;
    end
    else
    begin
      unique case (cstate)
        CS_IDLE:
        begin
          timer <= '0;
          if (act && prog_en && sep_is_write(c_op, c_sub))
          begin
            cstate <= CS_FILL;
            busy <= 1'b1;
            c_all <= (c_op == OP_SPECIAL);
            c_addr <= (c_op == OP_SPECIAL) ? '0 : hdr_sr[ADDR_W-1:0];
            c_data <= sep_is_erase(c_op, c_sub) ? ERASED_WORD : data_sr;
          end
        end
        CS_FILL:
        begin
          timer <= timer + 1'b1;
          if (!c_all || c_addr == LAST_ADDR)
          begin
            cstate <= CS_WAIT;
          end
          else
          begin
            c_addr <= c_addr + 1'b1;
          end
        end
        CS_WAIT:
        begin
          timer <= timer + 1'b1;
          if (timer >= PROG_LAST)
          begin
            cstate <= CS_IDLE;
            busy <= 1'b0;
          end
        end
        default:
        begin
          cstate <= CS_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

  assign mem_bus.wr_en = (cstate == CS_FILL);
  assign mem_bus.wr_addr = c_addr;
  assign mem_bus.wr_data = c_data;

  // status is shown only after a write, until the next start bit
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_mode <= 1'b0;
    end
    else if (low_s)
    begin
      status_mode <= 1'b0;
    end
    else if (busy)
    begin
      status_mode <= 1'b1;
    end
    else if (cs_s && start_s)
    begin
      status_mode <= 1'b0;
    end
  end

  // output pin
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      serial_data_out <= 1'b0;
      serial_data_oe <= 1'b0;
    end
    else if (!cs_s)
    begin
      serial_data_oe <= 1'b0;
    end
    else if (rdoe_s)
    begin
      serial_data_oe <= 1'b1;
      serial_data_out <= rdbit_s;
    end
    else if (status_mode && !start_s)
    begin
      serial_data_oe <= 1'b1;
      serial_data_out <= !busy;
    end
    else
    begin
      serial_data_oe <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_standby_off;
    @(posedge core_clk) disable iff (!rst_n)
    !cs_s |=> !serial_data_oe;
  endproperty
  a_standby_off: assert property (p_standby_off)
    else $error("output driven while deselected");

  property p_busy_low;
    @(posedge core_clk) disable iff (!rst_n)
    cs_s && status_mode && !start_s && !rdoe_s && busy
      |=> serial_data_oe && !serial_data_out;
  endproperty
  a_busy_low: assert property (p_busy_low)
    else $error("busy status not low");

  property p_ready_high;
    @(posedge core_clk) disable iff (!rst_n)
    cs_s && status_mode && !start_s && !rdoe_s && !busy
      |=> serial_data_oe && serial_data_out;
  endproperty
  a_ready_high: assert property (p_ready_high)
    else $error("ready status not high");

  property p_start_release;
    @(posedge core_clk) disable iff (!rst_n)
    cs_s && start_s && !rdoe_s |=> !serial_data_oe;
  endproperty
  a_start_release: assert property (p_start_release)
    else $error("start bit did not release output");

  property p_disabled_ignored;
    @(posedge core_clk) disable iff (!rst_n)
    act && !busy && !prog_en && sep_is_write(c_op, c_sub)
      |=> !busy [*3];
  endproperty
  a_disabled_ignored: assert property (p_disabled_ignored)
    else $error("write accepted while disabled");

  property p_enable_cmd;
    @(posedge core_clk) disable iff (!rst_n)
    act && !busy && !low_s && c_op == OP_SPECIAL && c_sub == SUB_PROG_ON
      |=> prog_en;
  endproperty
  a_enable_cmd: assert property (p_enable_cmd)
    else $error("enable command not taken");

  property p_low_supply;
    @(posedge core_clk) disable iff (!rst_n)
    low_s |=> !prog_en && !busy && !mem_bus.wr_en;
  endproperty
  a_low_supply: assert property (p_low_supply)
    else $error("low supply did not cancel programming");

  property p_prog_time;
    @(posedge core_clk) disable iff (!rst_n)
    $fell(busy) && !$past(low_s) |-> $past(timer) >= PROG_LAST;
  endproperty
  a_prog_time: assert property (p_prog_time)
    else $error("busy ended before the programming time");

  property p_single_word;
    @(posedge core_clk) disable iff (!rst_n)
    mem_bus.wr_en && !c_all && !low_s |=> !mem_bus.wr_en && busy;
  endproperty
  a_single_word: assert property (p_single_word)
    else $error("single word write not one cycle");

  property p_fill_walk;
    @(posedge core_clk) disable iff (!rst_n)
    mem_bus.wr_en && c_all && c_addr != LAST_ADDR && !low_s
      |=> mem_bus.wr_en && c_addr == ADDR_W'($past(c_addr) + 1'b1);
  endproperty
  a_fill_walk: assert property (p_fill_walk)
    else $error("array fill skipped an address");

  property p_dummy_clock;
    @(posedge serial_clock_in) disable iff (!link_rst_n)
    lstate == LS_IDLE && !serial_data_in |=> lstate == LS_IDLE;
  endproperty
  a_dummy_clock: assert property (p_dummy_clock)
    else $error("dummy clock taken as start");

  property p_read_lead;
    @(posedge serial_clock_in) disable iff (!link_rst_n)
    hdr_last && f_op == OP_READ |=> rd_oe && !rd_bit ##1 rd_oe;
  endproperty
  a_read_lead: assert property (p_read_lead)
    else $error("read did not lead with a low bit");

  property p_addr_wrap;
    @(posedge serial_clock_in) disable iff (!link_rst_n)
    lstate == LS_READ && word_bit == WBIT_LAST && rd_addr == LAST_ADDR
      |=> rd_addr == '0;
  endproperty
  a_addr_wrap: assert property (p_addr_wrap)
    else $error("read address did not wrap");

  c_prog_done: cover property (@(posedge core_clk) disable iff (!rst_n)
    $fell(busy) && cs_s);
  c_fill_all: cover property (@(posedge core_clk) disable iff (!rst_n)
    mem_bus.wr_en && c_all && c_addr == LAST_ADDR);
  c_read_wrap: cover property (@(posedge serial_clock_in)
    disable iff (!link_rst_n)
    lstate == LS_READ && word_bit == WBIT_LAST && rd_addr == LAST_ADDR);
endmodule
`default_nettype wire

/* sep_command_port_test.sv */
`default_nettype none
module sep_command_port_test
  import sep_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int PROG = 1000;
  localparam int LIMIT = 40000;

  logic core_clk = 1'b0;
  logic rst_n = 1'b1;
  logic low_supply_in = 1'b0;
  logic serial_clock_in;
  logic chip_select_in;
  logic serial_data_in;
  logic serial_data_out;
  logic serial_data_oe;
  int failures = 0;
  int checked = 0;
  int cycles = 0;

  always #10 core_clk = ~core_clk;

  sep_command_port #(.PROG_CYCLES(PROG)) dut (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .serial_clock_in(serial_clock_in),
    .chip_select_in(chip_select_in),
    .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out),
    .serial_data_oe(serial_data_oe),
    .low_supply_in(low_supply_in)
  );

  sep_host_model host (
    .serial_clock_in(serial_clock_in),
    .chip_select_in(chip_select_in),
    .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out),
    .serial_data_oe(serial_data_oe)
  );

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check_bit(input string what, input logic e,
                           input logic got);
    checked++;
    if (got !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, e, got);
    end
  endtask

  task automatic check_word(input string what, input logic [15:0] e,
                            input logic [15:0] got);
    checked++;
    if (got !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, e, got);
    end
  endtask

  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      failures = failures + 1;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // shared operations
  // ----------------------------------------------------------------
  // read two words; output lags two link edges behind its edge
  task automatic read_chk(input logic [8:0] a, input logic [15:0] e0,
                          input logic [15:0] e1, input int d);
    logic [15:0] w0;
    logic [15:0] w1;
    int b;
    host.frame({20'h0, 1'b1, OP_READ, a}, 12, d, 34);
    b = d + 13;
    check_bit("read lead oe", 1'b1, host.cap[b][1]);
    check_bit("read lead bit", 1'b0, host.cap[b][0]);
    for (int i = 0; i < 16; i++)
    begin
      w0[15-i] = host.cap[b+1+i][0];
      w1[15-i] = host.cap[b+17+i][0];
    end
    check_word("read word", e0, w0);
    check_word("next word", e1, w1);
  endtask

  // status poll after a write-class frame
  task automatic busy_chk(input logic busy);
    int n;
    n = 0;
    host.poll_open();
    repeat (6) @(negedge core_clk);
    if (!busy)
      check_bit("no status oe", 1'b0, serial_data_oe);
    else
    begin
      check_bit("status oe", 1'b1, serial_data_oe);
      check_bit("busy level", 1'b0, host.pin);
      while (host.pin !== 1'b1 && n < PROG + 100)
      begin
        @(negedge core_clk);
        n++;
      end
      check_bit("ready oe", 1'b1, serial_data_oe);
      check_bit("ready level", 1'b1, host.pin);
      check_bit("busy length", 1'b1, n > PROG - 60 && n < PROG);
      host.release_status();
      repeat (4) @(negedge core_clk);
      check_bit("status released", 1'b0, serial_data_oe);
    end
    host.poll_close();
  endtask

  task automatic special(input logic [1:0] sub);
    host.frame({20'h0, 1'b1, OP_SPECIAL, sub, 7'h00}, 12, 0, 0);
  endtask

  // supply dip long enough to pass the pin synchroniser
  task automatic low_pulse();
    @(posedge core_clk);
    low_supply_in <= 1'b1;
    repeat (5) @(posedge core_clk);
    low_supply_in <= 1'b0;
    repeat (5) @(posedge core_clk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_disabled();
    check_bit("reset oe", 1'b0, serial_data_oe);
    host.frame({1'b1, OP_WRITE, 9'h010, 4'h0, 16'h1234}, 32, 0, 0);
    busy_chk(1'b0);
    read_chk(9'h010, 16'hffff, 16'hffff, 0);
  endtask

  task automatic t_write_read();
    special(SUB_PROG_ON);
    host.frame({1'b1, OP_WRITE, 9'h1ff, 4'ha, 16'hbeef}, 32, 0, 0);
    busy_chk(1'b1);
    read_chk(9'h1ff, 16'hbeef, 16'hffff, 3);
    host.frame({20'h0, 1'b1, OP_ERASE, 9'h1ff}, 12, 0, 0);
    busy_chk(1'b1);
    read_chk(9'h1fe, 16'hffff, 16'hffff, 0);
  endtask

  task automatic t_whole_array();
    host.frame({4'h0, 1'b1, OP_SPECIAL, SUB_ALL_WRITE, 7'h33, 16'h5a5a},
               28, 0, 0);
    busy_chk(1'b1);
    read_chk(9'h0c7, 16'h5a5a, 16'h5a5a, 0);
    special(SUB_ALL_ERASE);
    busy_chk(1'b1);
    read_chk(9'h100, 16'hffff, 16'hffff, 0);
  endtask

  task automatic t_protect();
    special(SUB_PROG_OFF);
    host.frame({1'b1, OP_WRITE, 9'h002, 4'h0, 16'h0000}, 32, 0, 0);
    busy_chk(1'b0);
    special(SUB_PROG_ON);
    low_pulse();
    host.frame({20'h0, 1'b1, OP_ERASE, 9'h002}, 12, 0, 0);
    busy_chk(1'b0);
    host.frame({1'b1, OP_WRITE, 9'h002, 4'h0, 16'h0000}, 32, 0, 0);
    busy_chk(1'b0);
    read_chk(9'h002, 16'hffff, 16'hffff, 0);
    special(SUB_PROG_ON);
    host.frame({1'b1, OP_WRITE, 9'h002, 4'h0, 16'h0f0f}, 32, 0, 0);
    busy_chk(1'b1);
    read_chk(9'h002, 16'h0f0f, 16'hffff, 0);
    // a supply dip in mid-programming aborts the busy period
    host.frame({20'h0, 1'b1, OP_ERASE, 9'h003}, 12, 0, 0);
    low_pulse();
    busy_chk(1'b0);
  endtask

  initial
  begin
    rst_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_disabled();
    t_write_read();
    t_whole_array();
    t_protect();
    test_done();
  end
endmodule
`default_nettype wire

/* sep_host_model.sv */
`default_nettype none
module sep_host_model
  import sep_pkg::*;
(
  // link towards the device
  output logic serial_clock_in,
  output logic chip_select_in,
  output logic serial_data_in,
  // device output pin
  input wire logic serial_data_out,
  input wire logic serial_data_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // captured pin state, one entry per rising link edge
  // ----------------------------------------------------------------
  logic [1:0] cap [$];
  // pin as the host sees it: inverse of the last bit while released
  wire logic pin;

  assign pin = serial_data_oe ? serial_data_out : !serial_data_out;

  initial
  begin
    serial_clock_in = 1'b0;
    // select held for a moment so the reset edge reaches the link flops
    chip_select_in = 1'b1;
    serial_data_in = 1'b1;
    #1 chip_select_in = 1'b0;
  end

  // ----------------------------------------------------------------
  // link edges
  // ----------------------------------------------------------------
  // one 30 ns link period, data set up while clock low
  task automatic pulse(input logic d);
    serial_data_in = d;
    #15 serial_clock_in = 1'b1;
    #5 cap.push_back({serial_data_oe, pin});
    #10 serial_clock_in = 1'b0;
  endtask

  // whole frame, msb of the n bits first
  task automatic frame(input logic [31:0] bits, input int n,
                       input int dummy, input int tail);
    cap.delete();
    chip_select_in = 1'b1;
    #200;
    repeat (dummy) pulse(1'b0);
    for (int i = n - 1; i >= 0; i--) pulse(bits[i]);
    repeat (tail) pulse(1'b0);
    chip_select_in = 1'b0;
    serial_data_in = ~serial_data_in;
    #250;
  endtask

  // ----------------------------------------------------------------
  // status polling
  // ----------------------------------------------------------------
  task automatic poll_open();
    serial_data_in = 1'b0;
    chip_select_in = 1'b1;
  endtask

  // dummies let the device see ready on the link side first
  task automatic release_status();
    repeat (3) pulse(1'b0);
    pulse(1'b1);
  endtask

  task automatic poll_close();
    chip_select_in = 1'b0;
    serial_data_in = ~serial_data_in;
    #250;
  endtask
endmodule
`default_nettype wire

/* sep_mem.sv */
`default_nettype none
module sep_mem
  import sep_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = WORD_W
)
(
  // write side, core domain
  input wire logic wr_clk,
  // read side, link domain
  input wire logic rd_clk,
  // array port
  sep_mem_if.mem port
);
  logic [DW-1:0] store [0:(1<<AW)-1];

  // array starts out erased
  initial
  begin
    for (int i = 0; i < (1 << AW); i++)
    begin
      store[i] = ERASED_WORD;
    end
  end

  always_ff @(posedge wr_clk)
  begin
    if (port.wr_en)
    begin
      store[port.wr_addr] <= port.wr_data;
    end
  end

  // registered read data
  always_ff @(posedge rd_clk)
  begin
    port.rd_data <= store[port.rd_addr];
  end
endmodule
`default_nettype wire

/* sep_mem_if.sv */
`default_nettype none
interface sep_mem_if
  import sep_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = WORD_W
);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;

  modport ctrl (output wr_en, output wr_addr, output wr_data,
                output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data,
               input rd_addr, output rd_data);
endinterface
`default_nettype wire

/* sep_pkg.sv */
`default_nettype none
package sep_pkg;
  // ----------------------------------------------------------------
  // array shape and frame layout
  // ----------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam int WORD_W = 16;
  localparam int OP_W = 2;
  localparam int HDR_BITS = OP_W + ADDR_W;
  localparam int CNT_W = 5;
  localparam int WBIT_W = 4;
  localparam int SYNC_W = 6;
  localparam logic [WBIT_W-1:0] WBIT_LAST = 4'hf;
  localparam logic [ADDR_W-1:0] LAST_ADDR = 9'h1ff;
  localparam logic [WORD_W-1:0] ERASED_WORD = 16'hffff;

  // ----------------------------------------------------------------
  // opcodes and sub-codes in the top two address bits
  // ----------------------------------------------------------------
  localparam logic [OP_W-1:0] OP_SPECIAL = 2'h0;
  localparam logic [OP_W-1:0] OP_WRITE = 2'h1;
  localparam logic [OP_W-1:0] OP_READ = 2'h2;
  localparam logic [OP_W-1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] SUB_PROG_OFF = 2'h0;
  localparam logic [1:0] SUB_ALL_WRITE = 2'h1;
  localparam logic [1:0] SUB_ALL_ERASE = 2'h2;
  localparam logic [1:0] SUB_PROG_ON = 2'h3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CORE_CLK_HZ = 50_000_000;
  localparam int PROG_TIME_MS = 10;
  localparam int PROG_CYCLES_DEF = CORE_CLK_HZ / 1000 * PROG_TIME_MS;

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LS_IDLE = 3'h0,
    LS_HDR = 3'h1,
    LS_READ = 3'h3,
    LS_DATA = 3'h5,
    LS_DONE = 3'h7
  } sep_link_state_t;

  typedef enum logic [1:0] {
    CS_IDLE = 2'h0,
    CS_FILL = 2'h1,
    CS_WAIT = 2'h3
  } sep_core_state_t;

  // ----------------------------------------------------------------
  // command decoding
  // ----------------------------------------------------------------
  function automatic logic sep_needs_data(input logic [1:0] op,
                                          input logic [1:0] sub);
    return (op == OP_WRITE) || (op == OP_SPECIAL && sub == SUB_ALL_WRITE);
  endfunction

  function automatic logic sep_is_write(input logic [1:0] op,
                                        input logic [1:0] sub);
    return (op == OP_WRITE) || (op == OP_ERASE) ||
           (op == OP_SPECIAL &&
            (sub == SUB_ALL_WRITE || sub == SUB_ALL_ERASE));
  endfunction

  function automatic logic sep_is_erase(input logic [1:0] op,
                                        input logic [1:0] sub);
    return (op == OP_ERASE) || (op == OP_SPECIAL && sub == SUB_ALL_ERASE);
  endfunction
endpackage
`default_nettype wire
